// ==== rtl/tsop_defs.vh ====
// Constants of the transport stream output port
// Assumes inclusion by the port module only
`ifndef TSOP_DEFS_VH
`define TSOP_DEFS_VH
`define TSOP_DIV_HALF   4'h4
`define TSOP_PKT_LEN    8'hbc
`define TSOP_PKT_LAST   8'hbb
`define TSOP_IRQ_REGS   3'h5
`define TSOP_SEL_BIT    7
`endif

// ==== rtl/tsop_port.v ====
// Transport stream output port with error and interrupt pins
// Assumes byte stream, event and pin inputs from the decoder core
`timescale 1ns/1ns
`include "tsop_defs.vh"
module tsop_port (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  input  wire       clkEn,
  // Byte source
  input  wire [7:0] srcData,
  input  wire       srcStart,
  input  wire       srcValid,
  output wire       srcReady,
  // Clock select bits and external byte clock input
  input  wire       manualByteClock,
  input  wire       byteClockOutEnable,
  input  wire       extByteClockIn,
  // Transport pins
  input  wire       tsOutputDisable,
  output reg  [7:0] tsDataOut,
  output wire       tsDataOe,
  output reg        tsByteClockOut,
  output wire       tsByteClockOe,
  output reg        tsByteValid,
  output reg        tsPacketStart,
  // Error indication
  input  wire       errorIndicatorSelect,
  input  wire       uncorrectableBlock,
  input  wire       noSignal,
  output reg        blockErrorN,
  // Interrupt
  input  wire       irqEvent,
  input  wire       irqEnable,
  input  wire [2:0] irqRegRead,
  output wire       irqOut,
  output wire       irqOe
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] extClkSync_q;
  reg [1:0] disSync_q;
  reg       extClkPrev_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extClkSync_q <= 2'h0;
      disSync_q    <= 2'h3;
      extClkPrev_q <= 1'h0;
    end else if (clkEn) begin
      extClkSync_q <= {extClkSync_q[0], extByteClockIn};
      disSync_q    <= {disSync_q[0], tsOutputDisable};
      extClkPrev_q <= extClkSync_q[1];
    end
  end

  assign tsDataOe      = ~disSync_q[1];
  assign tsByteClockOe = ~disSync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Byte clock source select
  wire       useExt;

  assign useExt = manualByteClock & byteClockOutEnable;

  ////////////////////////////////////////////////////////////////////////
  // Internal byte clock divider
  reg  [3:0] div_q;
  reg  [3:0] div_d;
  reg        intClk_q;
  reg        intClk_d;
  wire       intToggle;

  assign intToggle = (div_q == (`TSOP_DIV_HALF - 4'h1));

  always @* begin
    div_d    = div_q + 4'h1;
    intClk_d = intClk_q;
    if (intToggle) begin
      div_d    = 4'h0;
      intClk_d = ~intClk_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q    <= 4'h0;
      intClk_q <= 1'h0;
    end else if (clkEn) begin
      div_q    <= div_d;
      intClk_q <= intClk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edges of both clock sources
  wire extRise;
  wire extFall;
  wire intRise;
  wire intFall;
  wire clkRise;
  wire clkFall;
  wire slotEnd;

  assign extRise = extClkSync_q[1] & ~extClkPrev_q;
  assign extFall = ~extClkSync_q[1] & extClkPrev_q;
  assign intRise = intToggle & ~intClk_q;
  assign intFall = intToggle & intClk_q;
  assign clkRise = useExt ? extRise : intRise;
  assign clkFall = useExt ? extFall : intFall;

  // Only a fall of the pin clock itself ends a slot; a source switch
  // while the pin is low must not move the data
  assign slotEnd = clkFall & tsByteClockOut;

  ////////////////////////////////////////////////////////////////////////
  // Byte clock output
  reg byteClk_d;

  always @* begin
    byteClk_d = tsByteClockOut;
    if (clkRise)
      byteClk_d = 1'h1;
    else if (clkFall)
      byteClk_d = 1'h0;
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      tsByteClockOut <= 1'h0;
    else if (clkEn)
      tsByteClockOut <= byteClk_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry buffer
  reg  [8:0] buf_q [0:1];
  reg        wrPtr_q;
  reg        wrPtr_d;
  reg        rdPtr_q;
  reg        rdPtr_d;
  reg  [1:0] cnt_q;
  reg  [1:0] cnt_d;
  wire       pop;
  wire       push;

  assign srcReady = (cnt_q != 2'h2);
  assign push     = srcValid & srcReady;
  assign pop      = slotEnd & (cnt_q != 2'h0);

  always @* begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    cnt_d   = cnt_q;
    if (push)
      wrPtr_d = ~wrPtr_q;
    if (pop)
      rdPtr_d = ~rdPtr_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 1'h0;
      rdPtr_q <= 1'h0;
      cnt_q   <= 2'h0;
    end else if (clkEn) begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q   <= cnt_d;
    end
  end

  // Buffer words, start flag above the byte
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_q[0] <= 9'h000;
      buf_q[1] <= 9'h000;
    end else if (clkEn && push) begin
      buf_q[wrPtr_q] <= {srcStart, srcData};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output byte slot, updated on falling edge of byte clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tsDataOut     <= 8'h00;
      tsByteValid   <= 1'h0;
      tsPacketStart <= 1'h0;
    end else if (clkEn && slotEnd) begin
      if (cnt_q != 2'h0) begin
        tsDataOut     <= buf_q[rdPtr_q][7:0];
        tsByteValid   <= 1'h1;
        tsPacketStart <= buf_q[rdPtr_q][8];
      end else begin
        tsByteValid   <= 1'h0;
        tsPacketStart <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block error
  always @(posedge clk or posedge rst) begin
    if (rst)
      blockErrorN <= 1'h1;
    else if (clkEn)
      blockErrorN <= errorIndicatorSelect ? ~noSignal
                                          : ~uncorrectableBlock;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt
  reg        irqPend_q;
  reg        irqPend_d;
  reg  [2:0] readMask_q;
  reg  [2:0] readMask_d;
  wire [2:0] readNext;
  wire       allRead;
  wire       evt;

  assign readNext = readMask_q | irqRegRead;
  assign allRead  = (readNext == 3'h7);
  assign evt      = irqEvent & irqEnable;

  // A new event wins over the last read and restarts the read set
  always @* begin
    irqPend_d  = irqPend_q;
    readMask_d = readMask_q;
    if (evt) begin
      irqPend_d  = 1'h1;
      readMask_d = 3'h0;
    end else if (irqPend_q) begin
      if (allRead) begin
        irqPend_d  = 1'h0;
        readMask_d = 3'h0;
      end else begin
        readMask_d = readNext;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqPend_q  <= 1'h0;
      readMask_q <= 3'h0;
    end else if (clkEn) begin
      irqPend_q  <= irqPend_d;
      readMask_q <= readMask_d;
    end
  end

  // Open drain: pin level fixed low, enable pulls it
  assign irqOut = 1'b0;
  assign irqOe  = irqPend_q;

endmodule // tsop_port

// ==== testbench/tsop_sink.sv ====
// Receiver model and free running external byte clock
// Fed with the resolved pin levels by the bench top
`timescale 1ns/1ns
module tsop_sink (
  input  wire       busClk,
  input  wire [7:0] busData,
  input  wire       busValid,
  input  wire       busStart,
  output reg        extClk = 1'b0,
  output reg  [7:0] lastByte = 8'h00,
  output reg  [7:0] nBytes = 8'h00,
  output reg  [7:0] nStarts = 8'h00
);
  always #40 extClk = ~extClk;
  always @(posedge busClk) if (busValid) begin
    lastByte <= busData;
    nBytes <= nBytes + 8'h01;
    nStarts <= nStarts + {7'h00, busStart};
  end
endmodule // tsop_sink

// ==== testbench/tsop_port_sva.sv ====
// Pin timing checks of the port
// Bound to tsop_port by the bench top
`timescale 1ns/1ns
module tsop_port_sva (
  input wire       clk, rst, manualByteClock, byteClockOutEnable,
  input wire       extByteClockIn, tsOutputDisable, tsDataOe, tsByteValid,
  input wire       tsByteClockOut, tsPacketStart, errorIndicatorSelect,
  input wire       noSignal, uncorrectableBlock, blockErrorN, irqOe,
  input wire       irqEvent, irqEnable, irqOut,
  input wire [7:0] tsDataOut
);
  wire ext = manualByteClock & byteClockOutEnable;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////
  off_hiz_a: assert property (tsOutputDisable [*5] |-> !tsDataOe)
    else $error("driven while off");
  on_drive_a: assert property (!tsOutputDisable [*5] |-> tsDataOe)
    else $error("idle while on");
  start_valid_a: assert property (tsPacketStart |-> tsByteValid)
    else $error("start alone");
  fall_edge_a: assert property (!$stable({tsDataOut, tsByteValid})
    |-> $fell(tsByteClockOut)) else $error("late update");
  byte_rate_a: assert property ($fell(tsByteClockOut) && !ext |->
    (!tsByteClockOut [*4] ##1 tsByteClockOut) or (##[1:5] ext))
    else $error("bad period");
  ext_clock_a: assert property (ext [*8] |->
    tsByteClockOut == $past(extByteClockIn, 3)) else $error("ext lost");
  err_pin_a: assert property (1 |=> blockErrorN ==
    ($past(errorIndicatorSelect) ? !$past(noSignal)
                                 : !$past(uncorrectableBlock)))
    else $error("bad error pin");
  irq_raise_a: assert property (irqEnable && irqEvent |=>
    irqOe && !irqOut) else $error("irq not raised");
  cover property ($rose(tsPacketStart));
  cover property ($fell(irqOe));
  cover property ($fell(tsDataOe));
endmodule // tsop_port_sva

// ==== testbench/tsop_port_tb_top.sv ====
// Bench top of the transport port
// Needs tsop_port, tsop_sink and tsop_port_sva
`timescale 1ns/1ns
module tsop_port_tb_top;
  reg        clk, rst, clkEn, srcStart, srcValid, manualByteClock, full;
  reg        byteClockOutEnable, tsOutputDisable, errorIndicatorSelect;
  reg        uncorrectableBlock, noSignal, irqEvent, irqEnable;
  reg  [2:0] irqRegRead;
  reg  [7:0] srcData;
  wire       srcReady, tsDataOe, tsByteClockOe, tsByteClockOut, tsByteValid;
  wire       tsPacketStart, blockErrorN, irqOut, irqOe, extByteClockIn;
  wire [7:0] tsDataOut, lastByte, nBytes, nStarts;
  integer    n_mismatch = 0, samples_checked = 0, cycles = 0, i;
  tsop_port i_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .srcData(srcData),
    .srcStart(srcStart), .srcValid(srcValid), .srcReady(srcReady),
    .manualByteClock(manualByteClock),
    .byteClockOutEnable(byteClockOutEnable),
    .extByteClockIn(extByteClockIn), .tsOutputDisable(tsOutputDisable),
    .tsDataOut(tsDataOut), .tsDataOe(tsDataOe),
    .tsByteClockOut(tsByteClockOut), .tsByteClockOe(tsByteClockOe),
    .tsByteValid(tsByteValid), .tsPacketStart(tsPacketStart),
    .errorIndicatorSelect(errorIndicatorSelect),
    .uncorrectableBlock(uncorrectableBlock), .noSignal(noSignal),
    .blockErrorN(blockErrorN), .irqEvent(irqEvent), .irqEnable(irqEnable),
    .irqRegRead(irqRegRead), .irqOut(irqOut), .irqOe(irqOe));
  tsop_sink i_sink (.busClk(tsByteClockOut & tsByteClockOe),
    .busData(tsDataOe ? tsDataOut : ~tsDataOut), .busValid(tsByteValid),
    .busStart(tsPacketStart), .extClk(extByteClockIn),
    .lastByte(lastByte), .nBytes(nBytes), .nStarts(nStarts));
  initial begin clk = 0; forever #4 clk = ~clk; end
  always @(posedge clk) if (++cycles == 5000) begin n_mismatch++; wrap_up; end
  task tick(input integer n); repeat (n) @(posedge clk); #1; endtask
  task chk(input ok); samples_checked++;
    if (!ok) begin n_mismatch++; $display("[ERR] %0t bad value", $time); end
  endtask
  task wrap_up; if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task send(input [7:0] d, input s); srcData = d; srcStart = s; srcValid = 1;
    while (srcReady !== 1) begin full = 1; tick(1); end
    tick(1);
  endtask
  task t_stream; full = 0; send(8'h47, 1); send(8'h11, 0); send(8'h22, 0);
    send(8'h33, 0); srcValid = 0; tick(60);
    chk(full === 1);
    chk(nBytes === 4 && lastByte === 8'h33);
    chk(nStarts === 1);
  endtask
  task t_off; tsOutputDisable = 1; tick(5);
    chk(tsDataOe === 0 && tsByteClockOe === 0);
    send(8'h5a, 1); srcValid = 0; tick(40); tsOutputDisable = 0; tick(5);
    chk(tsByteClockOe === 1 && nBytes === 4);
  endtask
  task t_err; for (i = 0; i < 8; i++) begin
      {errorIndicatorSelect, uncorrectableBlock, noSignal} = i; tick(2);
      chk(blockErrorN === !(i[2] ? i[0] : i[1]));
    end
  endtask
  task t_irq; irqEnable = 0; irqEvent = 1; tick(2);
    chk(irqOe === 0);
    irqEnable = 1; tick(1); irqEvent = 0;
    irqRegRead = 3'h5; tick(1);
    irqRegRead = 0; tick(3);
    chk(irqOe === 1 && irqOut === 0);
    irqRegRead = 3'h2; tick(1); irqRegRead = 0; tick(2);
    chk(irqOe === 0);
  endtask
  task t_ext; manualByteClock = 1; byteClockOutEnable = 1; tick(40);
    send(8'h9c, 1); srcValid = 0; tick(60);
    chk(nBytes === 5 && lastByte === 8'h9c);
  endtask
  initial begin
    {srcStart, srcValid, manualByteClock, byteClockOutEnable, irqEvent} = 0;
    {tsOutputDisable, errorIndicatorSelect, uncorrectableBlock, noSignal} = 0;
    {irqEnable, irqRegRead, srcData} = 0;
    rst = 1; clkEn = 1; tick(3); rst = 0; tick(10);
    t_stream; t_off; t_err; t_irq; t_ext; wrap_up;
  end
endmodule // tsop_port_tb_top
bind tsop_port tsop_port_sva i_sva (.clk(clk), .rst(rst),
  .manualByteClock(manualByteClock), .byteClockOutEnable(byteClockOutEnable),
  .extByteClockIn(extByteClockIn), .tsOutputDisable(tsOutputDisable),
  .tsDataOe(tsDataOe), .tsByteValid(tsByteValid),
  .tsByteClockOut(tsByteClockOut), .tsPacketStart(tsPacketStart),
  .errorIndicatorSelect(errorIndicatorSelect), .noSignal(noSignal),
  .uncorrectableBlock(uncorrectableBlock), .blockErrorN(blockErrorN),
  .irqOe(irqOe), .irqEvent(irqEvent), .irqEnable(irqEnable),
  .irqOut(irqOut), .tsDataOut(tsDataOut));
